// ===== field_frame_current_loop_pwm.sv
// Field-frame PI current loop with three complementary PWM phase pairs and converter interface
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "field_frame_params.svh"

// Overview of operation
// R1: Compare phase voltages against up/down triangle counter
// R2: Three phases, top and bottom, differential pairs
// R3: Digitise phase currents via external serial converters
// R4: Rotate measured currents into the field frame
// R5: Separate d/q loops, transform back to phases
// R6: One PI gain set for both axes
// R7: Quadrature command comes from servo output
// R8: Direct command comes from per-motor parameter
// R9: Diagnostic fixed quadrature command replaces servo
// R10: Loop parameter zero disables current-loop closure
// R11: Pins selectable as PWM, DAC or pulse-direction; DAC and pulse-direction modes here only turn both switches off
// R12: Device commutates; amplifier only converts power
// R13: Loop and commutation run every phase clock
// R14: Current feedback only phases A and B
// R15: Converter clock and strobe shared by four
// R16: Max phase clock at twice PWM frequency
// R17: Phase C current is minus A plus B
// R18: Complementary pairs with configurable dead time
module field_frame_current_loop_pwm
  import field_frame_pkg::*;
#(
  parameter int GROUP = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [5:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic signed [15:0] servo_quad_cmd,
  input wire logic phase_a_adc_data,
  input wire logic phase_b_adc_data,
  output logic [GROUP-1:0] converter_clock_out,
  output logic [GROUP-1:0] converter_strobe_out,
  output logic phase_update_tick,
  output diff_pair_t phase_a_high_side_cmd,
  output diff_pair_t phase_a_low_side_cmd,
  output diff_pair_t phase_b_high_side_cmd,
  output diff_pair_t phase_b_low_side_cmd,
  output diff_pair_t phase_c_high_side_cmd,
  output diff_pair_t phase_c_low_side_cmd
);

  // ****************************************************************
  // Fixed-point and byte-enable helpers
  // ****************************************************************
  function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
    if (x > 32'sd32767) begin
      return 16'sh7fff;
    end else if (x < -32'sd32768) begin
      return 16'sh8000;
    end else begin
      return x[15:0];
    end
  endfunction

  function automatic logic signed [15:0] mulq15(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    return sat16(p >>> 15);
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[k*8 +: 8] = wd[k*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // State and combinational terms
  // ****************************************************************
  loop_state_t s;
  loop_state_t next_s;
  avalon_req_t req;
  logic max_tick;
  logic phase_tick;
  logic signed [16:0] ic_w;
  logic signed [15:0] ic;
  logic signed [15:0] beta;
  logic signed [15:0] qcmd;
  logic signed [15:0] ed;
  logic signed [15:0] eq;
  logic signed [15:0] valpha;
  logic signed [15:0] vbeta;
  logic signed [15:0] vhalf;
  logic signed [15:0] vb_part;
  logic [2:0][15:0] vph;
  logic [2:0] raw;

  assign req = '{avs_read, avs_write, avs_address, avs_byteenable, avs_writedata};
  // Answer one cycle after the request appears
  assign avs_waitrequest = (req.read | req.write) & ~s.ack;
  assign avs_readdata = s.rdata;
  assign phase_update_tick = phase_tick;
  // R16: tick at both counter turnarounds
  assign max_tick = (!s.down && s.cnt >= s.peak) || (s.down && s.cnt == 16'h0000);
  assign phase_tick = max_tick && s.pdcnt == 4'h0;
  // R15: one converter pair fans out to the group
  assign converter_clock_out = {GROUP{s.adc_clk}};
  assign converter_strobe_out = {GROUP{s.adc_stb}};
  // R2: each command drives a true and inverted line
  assign phase_a_high_side_cmd = '{s.hi[0], ~s.hi[0]};
  assign phase_a_low_side_cmd = '{s.lo[0], ~s.lo[0]};
  assign phase_b_high_side_cmd = '{s.hi[1], ~s.hi[1]};
  assign phase_b_low_side_cmd = '{s.lo[1], ~s.lo[1]};
  assign phase_c_high_side_cmd = '{s.hi[2], ~s.hi[2]};
  assign phase_c_low_side_cmd = '{s.lo[2], ~s.lo[2]};

  // ****************************************************************
  // Field-frame maths
  // ****************************************************************
  always_comb begin
    // R17: phase C current inferred from A and B
    ic_w = -(17'(s.ia) + 17'(s.ib));
    ic = sat16(32'(ic_w));
    // R4: Clarke then Park into the field frame
    beta = mulq15(sat16(32'(s.ib) - 32'(ic)), `INV_SQRT3_Q15);
    // R7: servo output sets quadrature command
    // R9: diagnostic value overrides the servo output
    qcmd = s.diag ? s.diag_q : servo_quad_cmd;
    // R8: direct command from the per-motor parameter
    ed = sat16(32'(s.direct_mag) - 32'(s.id));
    eq = sat16(32'(qcmd) - 32'(s.iq));
    // R5: voltage commands back to the stator frame
    valpha = sat16(32'(mulq15(s.vd, s.cosv)) - 32'(mulq15(s.vq, s.sinv)));
    vbeta = sat16(32'(mulq15(s.vd, s.sinv)) + 32'(mulq15(s.vq, s.cosv)));
    vhalf = valpha >>> 1;
    vb_part = mulq15(vbeta, `HALF_SQRT3_Q15);
    vph[0] = valpha;
    vph[1] = sat16(32'(vb_part) - 32'(vhalf));
    vph[2] = sat16(-32'(vb_part) - 32'(vhalf));
    // R1: duty level against the up/down counter
    for (int i = 0; i < 3; i++) begin
      raw[i] = s.cnt < s.cmp[i];
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    // Bus slave; writes commit only on the edge after waitrequest falls, which ends the transfer
    next_s.ack = (req.read | req.write) & ~s.ack;
    if (req.read && !s.ack) begin
      unique case (req.address)
        `REG_CTRL: next_s.rdata = {28'h0000000, s.diag, s.mode, s.loop_en};
        `REG_DIRECT_MAG: next_s.rdata = {16'h0000, s.direct_mag};
        `REG_DIAG_QCMD: next_s.rdata = {16'h0000, s.diag_q};
        `REG_GAINS: next_s.rdata = {s.ki, s.kp};
        `REG_PWM_PEAK: next_s.rdata = {16'h0000, s.peak};
        `REG_DEADTIME: next_s.rdata = {24'h000000, s.dead};
        `REG_PHASE_DIV: next_s.rdata = {28'h0000000, s.pdiv};
        `REG_ANGLE: next_s.rdata = {s.sinv, s.cosv};
        `REG_CURRENT: next_s.rdata = {s.iq, s.id};
        `REG_VOLTAGE: next_s.rdata = {s.vq, s.vd};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    if (req.write && s.ack) begin
      unique case (req.address)
        `REG_CTRL: begin
          // R10: clearing the enable bit stops loop closure
          next_s.loop_en = req.byteenable[0] ? req.writedata[`CTRL_LOOP_EN] : s.loop_en;
          // R11: output function of the pins
          if (req.byteenable[0]) begin
            unique case (req.writedata[`CTRL_MODE_HI:`CTRL_MODE_LO])
              2'h1: next_s.mode = MODE_DAC;
              2'h2: next_s.mode = MODE_PULSE_DIR;
              default: next_s.mode = MODE_PWM;
            endcase
          end
          next_s.diag = req.byteenable[0] ? req.writedata[`CTRL_DIAG] : s.diag;
        end
        `REG_DIRECT_MAG: next_s.direct_mag = 16'(merge_be(32'(s.direct_mag), req.writedata,
                                                          req.byteenable));
        `REG_DIAG_QCMD: next_s.diag_q = 16'(merge_be(32'(s.diag_q), req.writedata,
                                                     req.byteenable));
        `REG_GAINS: {next_s.ki, next_s.kp} = merge_be({s.ki, s.kp}, req.writedata,
                                                     req.byteenable);
        `REG_PWM_PEAK: next_s.peak = 16'(merge_be(32'(s.peak), req.writedata, req.byteenable));
        `REG_DEADTIME: next_s.dead = req.byteenable[0] ? req.writedata[7:0] : s.dead;
        `REG_PHASE_DIV: next_s.pdiv = req.byteenable[0] ? req.writedata[3:0] : s.pdiv;
        `REG_ANGLE: {next_s.sinv, next_s.cosv} = merge_be({s.sinv, s.cosv}, req.writedata,
                                                         req.byteenable);
        default: next_s.rdata = s.rdata;
      endcase
    end

    // R1: triangle reference counter
    if (!s.down) begin
      next_s.down = s.cnt >= s.peak;
      next_s.cnt = (s.cnt >= s.peak) ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
    end else begin
      next_s.down = s.cnt != 16'h0000;
      next_s.cnt = (s.cnt == 16'h0000) ? 16'h0001 : s.cnt - 16'h0001;
    end
    if (max_tick) begin
      next_s.pdcnt = (s.pdcnt == 4'h0) ? s.pdiv : s.pdcnt - 4'h1;
    end

    // R3: serial converter read, pins synchronised first
    next_s.a_sync1 = phase_a_adc_data;
    next_s.a_sync2 = s.a_sync1;
    next_s.b_sync1 = phase_b_adc_data;
    next_s.b_sync2 = s.b_sync1;
    next_s.adc_stb = 1'b0;
    if (phase_tick && !s.adc_busy) begin
      next_s.adc_busy = 1'b1;
      next_s.adc_stb = 1'b1;
      // Two extra half periods let the last bit drain through the synchroniser
      next_s.adc_half = `CONV_HALF_PERIODS + `CONV_SYNC_LAG;
    end else if (s.adc_busy) begin
      // Clock stops for the drain tail so only 16 bits are clocked out
      next_s.adc_clk = (s.adc_half > `CONV_SYNC_LAG) ? ~s.adc_clk : 1'b0;
      next_s.adc_half = s.adc_half - 6'h01;
      // R14: only A and B feedback channels exist
      // Odd counts land mid-window of each bit after the two sync stages
      if (s.adc_half[0] && s.adc_half < `CONV_HALF_PERIODS) begin
        next_s.sh_a = {s.sh_a[14:0], s.a_sync2};
        next_s.sh_b = {s.sh_b[14:0], s.b_sync2};
      end
      if (s.adc_half == 6'h01) begin
        next_s.adc_busy = 1'b0;
        next_s.adc_clk = 1'b0;
        next_s.ia = {s.sh_a[14:0], s.a_sync2};
        next_s.ib = {s.sh_b[14:0], s.b_sync2};
      end
    end

    // R13: one loop and commutation pass per phase tick
    if (phase_tick) begin
      next_s.id = sat16(32'(mulq15(s.ia, s.cosv)) + 32'(mulq15(beta, s.sinv)));
      next_s.iq = sat16(32'(mulq15(beta, s.cosv)) - 32'(mulq15(s.ia, s.sinv)));
      // R12: device produces the phase voltage commands itself
      for (int i = 0; i < 3; i++) begin
        next_s.cmp[i] = 16'(32'(s.peak >> 1) + 32'(mulq15(vph[i], 16'(s.peak >> 1))));
      end
      if (s.loop_en) begin
        // R6: shared PI gains for both axes
        next_s.int_d = sat16(32'(s.int_d) + 32'(mulq15(s.ki, ed)));
        next_s.int_q = sat16(32'(s.int_q) + 32'(mulq15(s.ki, eq)));
        next_s.vd = sat16(32'(mulq15(s.kp, ed)) + 32'(next_s.int_d));
        next_s.vq = sat16(32'(mulq15(s.kp, eq)) + 32'(next_s.int_q));
      end else begin
        // R10: disabled loop holds zero voltage and clean integrators
        next_s.int_d = 16'sh0000;
        next_s.int_q = 16'sh0000;
        next_s.vd = 16'sh0000;
        next_s.vq = 16'sh0000;
      end
    end

    // R18: dead time on every transition of a phase
    for (int i = 0; i < 3; i++) begin
      if (raw[i] != s.applied[i]) begin
        next_s.applied[i] = raw[i];
        next_s.dtc[i] = s.dead;
      end else if (s.dtc[i] != 8'h00) begin
        next_s.dtc[i] = s.dtc[i] - 8'h01;
      end
      // Other pin functions are served elsewhere, so both switches stay off here
      next_s.hi[i] = s.mode == MODE_PWM && next_s.applied[i] && next_s.dtc[i] == 8'h00;
      next_s.lo[i] = s.mode == MODE_PWM && !next_s.applied[i] && next_s.dtc[i] == 8'h00;
    end

    if (!rst_n) begin
      next_s = '0;
      next_s.mode = MODE_PWM;
      next_s.peak = `RST_PWM_PEAK;
      next_s.dead = `RST_DEADTIME;
      next_s.pdiv = `RST_PHASE_DIV;
      next_s.cosv = `RST_COS;
      for (int i = 0; i < 3; i++) begin
        next_s.cmp[i] = `RST_PWM_PEAK >> 1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence conv_start_s;
    s.adc_stb && s.adc_busy;
  endsequence

  sequence conv_run_s;
    (s.adc_busy && !s.adc_stb) [*8];
  endsequence

  no_shoot_through_a: assert property (!(|(s.hi & s.lo))) // R18
    else $error("top and bottom on together");
  dead_gap_a: assert property ($fell(s.hi[0]) && s.dead != 8'h00 |=> !s.lo[0]) // R18
    else $error("low side on without dead time");
  diff_pair_a: assert property (phase_b_low_side_cmd.n == ~phase_b_low_side_cmd.p) // R2
    else $error("differential pair not complementary");
  strobe_shared_a: assert property (&converter_strobe_out || !(|converter_strobe_out)) // R15
    else $error("converter strobes differ in group");
  conv_seq_a: assert property (phase_tick && !s.adc_busy |=> conv_start_s ##1 conv_run_s) // R3
    else $error("converter sequence broken");
  tick_turn_a: assert property (phase_tick |-> max_tick) // R16
    else $error("phase tick off a counter turnaround");
  loop_off_a: assert property (phase_tick && !s.loop_en |=> // R10
    s.vd == 16'sh0000 && s.vq == 16'sh0000 && s.int_q == 16'sh0000)
    else $error("voltage command while loop disabled");
  ic_sum_a: assert property (32'(s.ia) + 32'(s.ib) > -32'sd32768 |-> // R17
    32'(ic) + 32'(s.ia) + 32'(s.ib) == 32'sd0)
    else $error("phase c current not minus a plus b");
  conv_clk_idle_a: assert property (!s.adc_busy |-> !s.adc_clk) // R15
    else $error("converter clock runs outside a conversion");
  strobe_pulse_a: assert property (s.adc_stb |=> !s.adc_stb) // R3
    else $error("converter strobe longer than one cycle");
  mode_off_a: assert property (s.mode != MODE_PWM |=> !(|s.hi) && !(|s.lo)) // R11
    else $error("switch command outside pwm mode");
  diag_sel_a: assert property (s.diag |-> qcmd == s.diag_q) // R9
    else $error("diagnostic quadrature command ignored");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one cycle");

endmodule

// ===== field_frame_params.svh
// Register offsets, field positions, reset values and timing counts of the PWM current loop
`ifndef FIELD_FRAME_PARAMS_SVH
`define FIELD_FRAME_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define REG_CTRL 6'h00
`define REG_DIRECT_MAG 6'h04
`define REG_DIAG_QCMD 6'h08
`define REG_GAINS 6'h0c
`define REG_PWM_PEAK 6'h10
`define REG_DEADTIME 6'h14
`define REG_PHASE_DIV 6'h18
`define REG_ANGLE 6'h1c
`define REG_CURRENT 6'h20
`define REG_VOLTAGE 6'h24

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_LOOP_EN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_DIAG 3

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_PWM_PEAK 16'h03e8
`define RST_DEADTIME 8'h0a
`define RST_PHASE_DIV 4'h0
`define RST_COS 16'h7fff

// ****************************************************************
// Converter and fixed-point constants
// ****************************************************************
`define ADC_BITS 5'h10
`define CONV_HALF_PERIODS 6'h20
`define CONV_SYNC_LAG 6'h02
`define INV_SQRT3_Q15 16'sh49e7
`define HALF_SQRT3_Q15 16'sh6eda

`endif

// ===== field_frame_pkg.sv
// Types of the field-frame current loop and PWM block
package field_frame_pkg;

  typedef enum logic [1:0] {
    MODE_PWM,
    MODE_DAC,
    MODE_PULSE_DIR
  } out_mode_t;

  typedef struct packed {
    logic p;
    logic n;
  } diff_pair_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avalon_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic loop_en;
    out_mode_t mode;
    logic diag;
    logic signed [15:0] direct_mag;
    logic signed [15:0] diag_q;
    logic signed [15:0] kp;
    logic signed [15:0] ki;
    logic [15:0] peak;
    logic [7:0] dead;
    logic [3:0] pdiv;
    logic signed [15:0] cosv;
    logic signed [15:0] sinv;
    logic [15:0] cnt;
    logic down;
    logic [3:0] pdcnt;
    logic a_sync1;
    logic a_sync2;
    logic b_sync1;
    logic b_sync2;
    logic adc_busy;
    logic [5:0] adc_half;
    logic adc_clk;
    logic adc_stb;
    logic [15:0] sh_a;
    logic [15:0] sh_b;
    logic signed [15:0] ia;
    logic signed [15:0] ib;
    logic signed [15:0] id;
    logic signed [15:0] iq;
    logic signed [15:0] int_d;
    logic signed [15:0] int_q;
    logic signed [15:0] vd;
    logic signed [15:0] vq;
    logic [2:0][15:0] cmp;
    logic [2:0] applied;
    logic [2:0][7:0] dtc;
    logic [2:0] hi;
    logic [2:0] lo;
  } loop_state_t;

endpackage

// ===== adc_pair_model.sv
// Serial converter pair model feeding phase A and B current samples
`timescale 1ns/1ps
module adc_pair_model (
  input wire logic core_clk,
  input wire logic conv_clk,
  input wire logic conv_stb,
  input wire logic [15:0] val_a,
  input wire logic [15:0] val_b,
  output logic data_a,
  output logic data_b
);
  logic [15:0] sh_a = 16'h0000;
  logic [15:0] sh_b = 16'h0000;
  logic [4:0] left = 5'h00;
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  // ****************************************************************
  // Shift on the falling converter clock, MSB first
  // ****************************************************************
  // only phases A and B report current
  always @(posedge core_clk) begin
    if (conv_stb) begin
      sh_a <= val_a;
      sh_b <= val_b;
      left <= 5'h10;
    end else if (conv_clk && left != 5'h00) begin
      last_a <= sh_a[15];
      last_b <= sh_b[15];
      sh_a <= {sh_a[14:0], 1'b0};
      sh_b <= {sh_b[14:0], 1'b0};
      left <= left - 5'h01;
    end
  end
  // Released line has no pull; inverse of last bit so stale data never looks valid
  assign data_a = (left != 5'h00) ? sh_a[15] : ~last_a;
  assign data_b = (left != 5'h00) ? sh_b[15] : ~last_b;
endmodule

// ===== tb.sv
// Self-checking bench of the field-frame current loop and PWM block
`timescale 1ns/1ps
`include "field_frame_params.svh"
module tb;
  import field_frame_pkg::*;
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] rst;
    logic [31:0] wd;
    logic [3:0] be;
    logic [31:0] exp;
  } row_t;
  localparam int DEAD_SET = 3;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic signed [15:0] servo_quad_cmd = 16'sh0000;
  logic adc_a, adc_b, tick;
  logic [3:0] conv_clk, conv_stb;
  logic [15:0] val_a = 16'h0000;
  diff_pair_t hs [3];
  diff_pair_t ls [3];
  int failures = 0;
  int cmp_count = 0;
  int gap [3] = '{0, 0, 0};
  int rises = 0;
  logic seen = 1'b0;
  logic clk_q = 1'b0;
  logic stb_q = 1'b0;
  logic [31:0] rd;
  int h, l, g;
  row_t rows [13] = '{
    '{`REG_CTRL, 32'h0, 32'h4, 4'h1, 32'h4},
    '{`REG_DIRECT_MAG, 32'h0, 32'h1234, 4'hf, 32'h1234},
    '{`REG_DIRECT_MAG, 32'h1234, 32'h5678, 4'h1, 32'h1278},
    '{`REG_DIAG_QCMD, 32'h0, 32'h7000, 4'h3, 32'h7000},
    '{`REG_GAINS, 32'h0, 32'h12345678, 4'hf, 32'h12345678},
    '{`REG_GAINS, 32'h12345678, 32'habcd0000, 4'hc, 32'habcd5678},
    '{`REG_PWM_PEAK, 32'h3e8, 32'h28, 4'hf, 32'h28},
    '{`REG_DEADTIME, 32'ha, 32'h3, 4'h1, 32'h3},
    '{`REG_PHASE_DIV, 32'h0, 32'hf, 4'h1, 32'hf},
    '{`REG_ANGLE, 32'h7fff, 32'h7fff, 4'hf, 32'h7fff},
    '{`REG_CURRENT, 32'h0, 32'hffffffff, 4'hf, 32'h0},
    '{`REG_VOLTAGE, 32'h0, 32'hffffffff, 4'hf, 32'h0},
    '{6'h28, 32'h0, 32'hffffffff, 4'hf, 32'h0}
  };

  field_frame_current_loop_pwm #(.GROUP(4)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_address(avs_address), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .servo_quad_cmd(servo_quad_cmd),
    .phase_a_adc_data(adc_a), .phase_b_adc_data(adc_b),
    .converter_clock_out(conv_clk), .converter_strobe_out(conv_stb),
    .phase_update_tick(tick), .phase_a_high_side_cmd(hs[0]), .phase_a_low_side_cmd(ls[0]),
    .phase_b_high_side_cmd(hs[1]), .phase_b_low_side_cmd(ls[1]),
    .phase_c_high_side_cmd(hs[2]), .phase_c_low_side_cmd(ls[2])
  );
  adc_pair_model partner (
    .core_clk(core_clk), .conv_clk(conv_clk[0]), .conv_stb(conv_stb[0]),
    .val_a(val_a), .val_b(16'h0000), .data_a(adc_a), .data_b(adc_b)
  );

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Checks and bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic chk_rng(input string nm, input logic signed [31:0] lo,
                         input logic signed [31:0] hi, input logic signed [31:0] v);
    cmp_count++;
    if (((v >= lo) && (v <= hi)) !== 1'b1) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask
  // Slave always answers after one wait cycle; a hang is cut at 50
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] q);
    int waits;
    waits = 0;
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= wd;
    forever begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0 || waits > 50) break;
      waits++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("wait_cycles", 32'd1, 32'(waits));
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] dummy;
    xfer(1'b1, a, wd, be, dummy);
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("cmds_after_reset", 32'h0, 32'({hs[0].p, hs[1].p, hs[2].p, ls[0].p, ls[1].p, ls[2].p}));
  endtask
  task automatic tick_gap(output int n);
    int k;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (tick !== 1'b1 && k < 4000);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (tick !== 1'b1 && n < 4000);
  endtask
  task automatic duty(output int hi, output int on);
    hi = 0;
    on = 0;
    repeat (80) begin
      @(negedge core_clk);
      hi += int'(hs[0].p === 1'b1);
      on += int'((hs[0].p | ls[0].p | hs[1].p | ls[1].p | hs[2].p | ls[2].p) !== 1'b0);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Monitors of pin pairs and converter interface
  // ****************************************************************
  always @(negedge core_clk) begin
    if (rst_n !== 1'b1) begin
      seen = 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // never both on, n is inverse of p
        chk("pair_state", 32'h3, 32'({hs[i].p & ls[i].p, hs[i].n ^ hs[i].p, ls[i].n ^ ls[i].p}));
        if (hs[i].p === 1'b1 || ls[i].p === 1'b1) begin
          if (gap[i] != 0) chk_rng("dead_gap", DEAD_SET, 1000000, gap[i]);
          gap[i] = 0;
        end else gap[i]++;
      end
      chk("conv_group", {24'h0, {4{conv_clk[0]}}, {4{conv_stb[0]}}},
          {24'h0, conv_clk, conv_stb});
      if (conv_clk[0] === 1'b1 && clk_q === 1'b0) rises++;
      if (conv_stb[0] === 1'b1) begin
        chk("strobe_width", 32'h0, 32'(stb_q));
        if (seen) chk("conv_clocks", 32'd16, 32'(rises));
        seen = 1'b1;
        rises = 0;
      end
      clk_q = conv_clk[0];
      stb_q = conv_stb[0];
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    foreach (rows[i]) begin
      xfer(1'b0, rows[i].addr, 32'h0, 4'hf, rd);
      chk("reg_before", rows[i].rst, rd);
      wr(rows[i].addr, rows[i].wd, rows[i].be);
      xfer(1'b0, rows[i].addr, 32'h0, 4'hf, rd);
      chk("reg_after", rows[i].exp, rd);
    end
    do_reset();
    xfer(1'b0, `REG_PWM_PEAK, 32'h0, 4'hf, rd);
    chk("peak_after_reset", 32'h3e8, rd);
    wr(`REG_PWM_PEAK, 32'h28, 4'hf);
    wr(`REG_DEADTIME, 32'(DEAD_SET), 4'h1);
    wr(`REG_GAINS, 32'h10002000, 4'hf);
    tick_gap(g);
    chk("tick_gap", 32'd40, 32'(g));
    wr(`REG_PHASE_DIV, 32'h2, 4'h1);
    tick_gap(g);
    tick_gap(g);
    chk("tick_gap_div", 32'd120, 32'(g));
    wr(`REG_PHASE_DIV, 32'h0, 4'h1);
    duty(h, l);
    chk_rng("duty_half", 33, 39, h);
    xfer(1'b0, `REG_VOLTAGE, 32'h0, 4'hf, rd);
    chk("volt_loop_off", 32'h0, rd);
    val_a <= 16'h1000;
    repeat (200) @(posedge core_clk);
    xfer(1'b0, `REG_CURRENT, 32'h0, 4'hf, rd);
    chk_rng("id", 4088, 4100, $signed(rd[15:0]));
    chk_rng("iq", 2355, 2375, $signed(rd[31:16]));
    wr(`REG_DIRECT_MAG, 32'h7000, 4'h3);
    servo_quad_cmd <= 16'sh2000;
    wr(`REG_CTRL, 32'h1, 4'h1);
    repeat (400) @(posedge core_clk);
    xfer(1'b0, `REG_VOLTAGE, 32'h0, 4'hf, rd);
    chk_rng("vd", 1, 32767, $signed(rd[15:0]));
    chk_rng("vq_servo", 1, 32767, $signed(rd[31:16]));
    duty(h, l);
    chk_rng("duty_driven", 40, 80, h);
    wr(`REG_DIAG_QCMD, 32'hc000, 4'h3);
    wr(`REG_CTRL, 32'h9, 4'h1);
    repeat (400) @(posedge core_clk);
    xfer(1'b0, `REG_VOLTAGE, 32'h0, 4'hf, rd);
    chk_rng("vq_diag", -32768, -1, $signed(rd[31:16]));
    chk_rng("vd_shared_gain", 1, 32767, $signed(rd[15:0]));
    for (int m = 1; m < 3; m++) begin
      wr(`REG_CTRL, 32'(m << 1), 4'h1);
      repeat (4) @(posedge core_clk);
      duty(h, l);
      chk("cmds_other_mode", 32'h0, 32'(l));
    end
    end_of_test();
  end
endmodule
